// ### rtl/fdr_pkg.sv
// Package: register map, field layout, reset values and timing counts
package fdr_pkg;
   // Register offsets
   localparam logic [7:0] FDR_ADDR_REVISION = 8'h00;
   localparam logic [7:0] FDR_ADDR_MONITOR = 8'h01;
   localparam logic [7:0] FDR_ADDR_TORCH_RAMP = 8'h06;
   localparam logic [7:0] FDR_ADDR_FEATURES = 8'h08;
   localparam logic [7:0] FDR_ADDR_CURRENT = 8'h09;
   localparam logic [7:0] FDR_ADDR_ENABLE = 8'h0A;
   localparam logic [7:0] FDR_ADDR_FLAGS = 8'h0B;
   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] FDR_RST_MONITOR = 8'h80;
   localparam logic [7:0] FDR_RST_TORCH_RAMP = 8'h00;
   localparam logic [7:0] FDR_RST_FEATURES = 8'h52;
   localparam logic [7:0] FDR_RST_CURRENT = 8'h0F;
   localparam logic [7:0] FDR_RST_ENABLE = 8'h00;
   localparam logic [7:0] FDR_RST_FLAGS = 8'h00;
   // Arbitrary revision value, not tied to any part
   localparam logic [7:0] FDR_REVISION_DEF = 8'h5A;
   ////////////////////////////////////////////////////////////////////////
   // Writable bit masks; reserved bits read as zero
   localparam logic [7:0] FDR_WMASK_MONITOR = 8'h9C;
   localparam logic [7:0] FDR_WMASK_TORCH_RAMP = 8'h3F;
   localparam logic [7:0] FDR_WMASK_FEATURES = 8'h7F;
   localparam logic [7:0] FDR_WMASK_CURRENT = 8'h7F;
   localparam logic [7:0] FDR_WMASK_ENABLE = 8'hF3;
   ////////////////////////////////////////////////////////////////////////
   // Enable register fields
   localparam int FDR_EN_MONITOR_BIT = 7;
   localparam int FDR_EN_TX_BIT = 6;
   localparam int FDR_EN_STROBE_BIT = 5;
   localparam int FDR_EN_TORCH_PIN_BIT = 4;
   localparam int FDR_EN_MODE_LSB = 0;
   // Monitor register fields
   localparam int FDR_MON_UNDERVOLTAGE_LOCKOUT_BIT = 7;
   localparam int FDR_MON_THR_LSB = 2;
   // Features register fields
   localparam int FDR_FEAT_ILIM_BIT = 6;
   localparam int FDR_FEAT_RAMP_LSB = 3;
   localparam int FDR_FEAT_TOUT_LSB = 0;
   // Current register fields
   localparam int FDR_CUR_TORCH_LSB = 4;
   localparam int FDR_CUR_FLASH_LSB = 0;
   // Flag bit positions
   localparam int FDR_FLG_TIMEOUT = 0;
   localparam int FDR_FLG_THERMAL = 1;
   localparam int FDR_FLG_SHORT = 2;
   localparam int FDR_FLG_OVERVOLT = 3;
   localparam int FDR_FLG_UNDERVOLTAGE_LOCKOUT = 4;
   localparam int FDR_FLG_MONITOR = 5;
   ////////////////////////////////////////////////////////////////////////
   // Operating modes
   localparam logic [1:0] FDR_MODE_STANDBY = 2'h0;
   localparam logic [1:0] FDR_MODE_INDICATOR = 2'h1;
   localparam logic [1:0] FDR_MODE_TORCH = 2'h2;
   localparam logic [1:0] FDR_MODE_FLASH = 2'h3;
   ////////////////////////////////////////////////////////////////////////
   // Timing: time-out step of 100 ms per code, clock of 125 MHz
   localparam int FDR_CLK_KHZ = 125_000;
   localparam int FDR_TOUT_STEP_MS = 100;
   localparam int FDR_TOUT_STEP_CYC = FDR_TOUT_STEP_MS * FDR_CLK_KHZ;
endpackage

// ### rtl/fdr_flash_timer.sv
// Flash time-out timer: counts (code + 1) steps while running
`timescale 1ns/1ps
module fdr_flash_timer #(
   parameter int STEP_CYC = 12_500_000,
   parameter int CODE_W = 3
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic run_i,
   input wire logic [CODE_W-1:0] code_i,
   output logic expire_o
);
   localparam logic [31:0] STEP_LAST = 32'(STEP_CYC - 1);
   logic [31:0] pre_r;
   logic [CODE_W-1:0] step_r;
   logic tick;

   assign tick = (pre_r == STEP_LAST);

   ////////////////////////////////////////////////////////////////////////
   // Prescaler and step count restart whenever the flash stops
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || !run_i) begin
         pre_r <= 32'h0000_0000;
      end else if (tick) begin
         pre_r <= 32'h0000_0000;
      end else begin
         pre_r <= pre_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || !run_i) begin
         step_r <= '0;
      end else if (tick && step_r != code_i) begin
         step_r <= step_r + CODE_W'(1);
      end
   end

   // One-cycle pulse at the end of the last step
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         expire_o <= 1'b0;
      end else begin
         expire_o <= run_i && tick && (step_r == code_i) && !expire_o;
      end
   end
endmodule // fdr_flash_timer

// ### rtl/fdr_flash_driver_regs.sv
// Flash driver register bank with mode control and fault flags
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////
// Contract
// - Latched fault holds standby until flag read
// - Flags alone never block mode requests
// - After read, flags stay set only if still present
// - Monitor threshold crossing sets flag bit 5
// - Overvoltage trip sets flag bit 3
// - Thermal shutdown sets flag bit 1
// - Stop-and-hold freezes ramp for rest of flash
// - Stop-and-hold crossing sets monitor flag
// - Enabled undervoltage forces standby, sets flag
// - Monitor register bit 7 enables undervoltage lockout
// - Threshold code 000..111 is 2.9..3.6 V
// - Register flash clears mode bits at time-out
// - Short or output fault clears mode bits
module fdr_flash_driver_regs
   import fdr_pkg::*;
#(
   parameter int TOUT_STEP_CYC = FDR_TOUT_STEP_CYC,
   parameter logic [7:0] REVISION = FDR_REVISION_DEF
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   input wire logic strobe_i,
   input wire logic tx_i,
   input wire logic torch_pin_i,
   input wire logic vin_below_monitor_i,
   input wire logic vin_below_undervoltage_lockout_i,
   input wire logic overvolt_i,
   input wire logic led_short_i,
   input wire logic thermal_i,
   output logic [1:0] active_mode_o,
   output logic ramp_hold_o,
   output logic [2:0] monitor_down_threshold_o,
   output logic [3:0] flash_code_o,
   output logic [2:0] torch_code_o,
   output logic [2:0] flash_ramp_o,
   output logic inductor_limit_o,
   output logic [2:0] torch_ramp_up_o,
   output logic [2:0] torch_ramp_down_o
);
   typedef enum logic [2:0] {
      FDR_FL_IDLE = 3'b001,
      FDR_FL_RUN = 3'b010,
      FDR_FL_END = 3'b100
   } fdr_flash_state_t;

   logic [7:0] enable_r;
   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic [7:0] monitor_r;
   logic [7:0] ramp_r;
   logic [7:0] features_r;
   logic [7:0] current_r;
   logic [7:0] rdata_r;
   logic [1:0] mode_r;
   logic [1:0] mode_nxt;
   logic hold_r;
   logic lock_r;
   logic below_d_r;
   logic strobe_run_r;
   fdr_flash_state_t fl_state_r;
   logic [7:0] flag_set;
   logic flag_rd;
   logic fault_evt;
   logic undervoltage_lockout_evt;
   logic active;
   logic flash_req;
   logic expire;
   logic strobe_end;
   logic mode_clr;
   logic [1:0] mode_bits;

   ////////////////////////////////////////////////////////////////////////
   // Event decode
   assign mode_bits = enable_r[FDR_EN_MODE_LSB +: 2];
   assign active = (mode_r != FDR_MODE_STANDBY);
   assign flag_rd = rd_en_i && (addr_i == FDR_ADDR_FLAGS);
   assign undervoltage_lockout_evt = monitor_r[FDR_MON_UNDERVOLTAGE_LOCKOUT_BIT] && vin_below_undervoltage_lockout_i;
   // A pin-gated flash waits for the strobe level while armed
   assign flash_req = (mode_bits == FDR_MODE_FLASH) && !lock_r
      && (!enable_r[FDR_EN_STROBE_BIT] || strobe_i);
   assign strobe_end = (fl_state_r == FDR_FL_RUN) && strobe_run_r
      && !strobe_i && !expire;

   always_comb begin
      flag_set = 8'h00;
      flag_set[FDR_FLG_TIMEOUT] = expire;
      flag_set[FDR_FLG_THERMAL] = thermal_i;
      // Output faults are only judged while the source is driven
      flag_set[FDR_FLG_SHORT] = led_short_i && active;
      flag_set[FDR_FLG_OVERVOLT] = overvolt_i && active;
      flag_set[FDR_FLG_UNDERVOLTAGE_LOCKOUT] = undervoltage_lockout_evt;
      flag_set[FDR_FLG_MONITOR] = vin_below_monitor_i && !below_d_r;
   end

   assign fault_evt = |flag_set[FDR_FLG_UNDERVOLTAGE_LOCKOUT:FDR_FLG_THERMAL];
   // Hardware clears of the mode bits
   assign mode_clr = flag_set[FDR_FLG_SHORT]
      || flag_set[FDR_FLG_OVERVOLT]
      || undervoltage_lockout_evt
      || (expire && !strobe_run_r)
      || strobe_end || (expire && strobe_run_r);

   ////////////////////////////////////////////////////////////////////////
   // Time-out timer
   fdr_flash_timer #(
      .STEP_CYC(TOUT_STEP_CYC),
      .CODE_W(3)
   ) u_timer (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .run_i(fl_state_r == FDR_FL_RUN),
      .code_i(features_r[FDR_FEAT_TOUT_LSB +: 3]),
      .expire_o(expire)
   );

   ////////////////////////////////////////////////////////////////////////
   // Flash sequencer
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         fl_state_r <= FDR_FL_IDLE;
      end else begin
         case (fl_state_r)
            FDR_FL_IDLE: begin
               if (flash_req && !mode_clr) begin
                  fl_state_r <= FDR_FL_RUN;
               end
            end
            FDR_FL_RUN: begin
               if (expire || mode_clr || lock_r) begin
                  fl_state_r <= FDR_FL_END;
               end else if (!flash_req) begin
                  fl_state_r <= FDR_FL_IDLE;
               end
            end
            FDR_FL_END: begin
               fl_state_r <= FDR_FL_IDLE;
            end
            default: begin
               fl_state_r <= FDR_FL_IDLE;
            end
         endcase
      end
   end

   // Remember whether the running flash was gated by the strobe pin
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         strobe_run_r <= 1'b0;
      end else if (fl_state_r == FDR_FL_IDLE) begin
         strobe_run_r <= enable_r[FDR_EN_STROBE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Stop-and-hold: freeze the ramp until the flash ends
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         below_d_r <= 1'b0;
      end else begin
         below_d_r <= vin_below_monitor_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || fl_state_r != FDR_FL_RUN) begin
         hold_r <= 1'b0;
      end else if (enable_r[FDR_EN_MONITOR_BIT] && vin_below_monitor_i
         && mode_r == FDR_MODE_FLASH) begin
         // Only a flash that is already driven can have its ramp frozen
         hold_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault lock; only the flag read re-arms, a new fault in that cycle wins
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         lock_r <= 1'b0;
      end else if (fault_evt) begin
         lock_r <= 1'b1;
      end else if (flag_rd) begin
         lock_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags: read clears, set wins over the clear
   always_comb begin
      flags_nxt = flags_r;
      if (flag_rd) begin
         flags_nxt = 8'h00;
      end
      flags_nxt = flags_nxt | flag_set;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         flags_r <= FDR_RST_FLAGS;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable register; hardware clear of mode bits beats a host write
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         enable_r <= FDR_RST_ENABLE;
      end else begin
         if (wr_en_i && addr_i == FDR_ADDR_ENABLE) begin
            enable_r <= wdata_i & FDR_WMASK_ENABLE;
         end
         if (mode_clr) begin
            enable_r[FDR_EN_MODE_LSB +: 2] <= FDR_MODE_STANDBY;
         end
      end
   end

   // Plain configuration registers
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         monitor_r <= FDR_RST_MONITOR;
         ramp_r <= FDR_RST_TORCH_RAMP;
         features_r <= FDR_RST_FEATURES;
         current_r <= FDR_RST_CURRENT;
      end else if (wr_en_i) begin
         case (addr_i)
            FDR_ADDR_MONITOR: monitor_r <= wdata_i & FDR_WMASK_MONITOR;
            FDR_ADDR_TORCH_RAMP: ramp_r <= wdata_i & FDR_WMASK_TORCH_RAMP;
            FDR_ADDR_FEATURES: features_r <= wdata_i & FDR_WMASK_FEATURES;
            FDR_ADDR_CURRENT: current_r <= wdata_i & FDR_WMASK_CURRENT;
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the request; unmapped reads give zero
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         rdata_r <= 8'h00;
      end else if (rd_en_i) begin
         case (addr_i)
            FDR_ADDR_REVISION: rdata_r <= REVISION;
            FDR_ADDR_MONITOR: rdata_r <= monitor_r;
            FDR_ADDR_TORCH_RAMP: rdata_r <= ramp_r;
            FDR_ADDR_FEATURES: rdata_r <= features_r;
            FDR_ADDR_CURRENT: rdata_r <= current_r;
            FDR_ADDR_ENABLE: rdata_r <= enable_r;
            FDR_ADDR_FLAGS: rdata_r <= flags_r;
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Active mode; flags are not consulted here, only the fault lock and the fault events of this cycle
   always_comb begin
      mode_nxt = FDR_MODE_STANDBY;
      if (lock_r || fault_evt || undervoltage_lockout_evt) begin
         mode_nxt = FDR_MODE_STANDBY;
      end else if (fl_state_r == FDR_FL_RUN && !expire && !mode_clr) begin
         // TX pin drops a running flash to torch level
         mode_nxt = (enable_r[FDR_EN_TX_BIT] && tx_i) ?
            FDR_MODE_TORCH : FDR_MODE_FLASH;
      end else if (enable_r[FDR_EN_TORCH_PIN_BIT] && torch_pin_i) begin
         mode_nxt = FDR_MODE_TORCH;
      end else if (mode_bits != FDR_MODE_FLASH && !mode_clr) begin
         mode_nxt = mode_bits;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         mode_r <= FDR_MODE_STANDBY;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops
   assign rdata_o = rdata_r;
   assign active_mode_o = mode_r;
   assign ramp_hold_o = hold_r;
   // Code 0 is 2.9 V, each step adds 0.1 V
   assign monitor_down_threshold_o = monitor_r[FDR_MON_THR_LSB +: 3];
   assign flash_code_o = current_r[FDR_CUR_FLASH_LSB +: 4];
   assign torch_code_o = current_r[FDR_CUR_TORCH_LSB +: 3];
   assign flash_ramp_o = features_r[FDR_FEAT_RAMP_LSB +: 3];
   assign inductor_limit_o = features_r[FDR_FEAT_ILIM_BIT];
   assign torch_ramp_up_o = ramp_r[5:3];
   assign torch_ramp_down_o = ramp_r[2:0];
endmodule // fdr_flash_driver_regs

// ### verification/fdr_host_model.sv
// Host-side model: byte-level register reads and writes
`timescale 1ns/1ps
module fdr_host_model (
   input wire logic clk_sys_i,
   input wire logic [7:0] rdata_i,
   output logic wr_en_o,
   output logic rd_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   // Requests change on the falling edge and span one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_sys_i);
      addr_o = a;
      wdata_o = v;
      wr_en_o = 1'b1;
      @(negedge clk_sys_i);
      wr_en_o = 1'b0;
      wdata_o = ~v; // No stale data left on the bus
   endtask
   // Reading the flags is the only way to re-arm after a fault
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk_sys_i);
      addr_o = a;
      rd_en_o = 1'b1;
      @(negedge clk_sys_i);
      rd_en_o = 1'b0;
      v = rdata_i;
   endtask
endmodule // fdr_host_model

// ### verification/fdr_regs_monitor.sv
// Checker: port-level relations of the flash driver register bank
`timescale 1ns/1ps
module fdr_regs_monitor
   import fdr_pkg::*;
#(
   parameter logic [7:0] REVISION = FDR_REVISION_DEF
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic rd_en_i,
   input wire logic wr_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   input wire logic vin_below_monitor_i,
   input wire logic overvolt_i,
   input wire logic led_short_i,
   input wire logic thermal_i,
   input wire logic [1:0] active_mode_o,
   input wire logic ramp_hold_o,
   input wire logic [2:0] monitor_down_threshold_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////////////////////////////////////
   a_thermal_stop: assert property (thermal_i |=> active_mode_o == 2'h0)
      else $error("thermal fault left mode active");
   a_fault_lock: assert property (thermal_i ##1
      !(rd_en_i && addr_i == FDR_ADDR_FLAGS) [*4] |=> active_mode_o == 2'h0)
      else $error("mode resumed without flag read");
   a_short_stop: assert property
      (led_short_i && active_mode_o != 2'h0 |=> active_mode_o == 2'h0)
      else $error("short did not stop mode");
   a_ovp_stop: assert property
      (overvolt_i && active_mode_o != 2'h0 |=> active_mode_o == 2'h0)
      else $error("overvoltage did not stop mode");
   a_hold_cause: assert property ($rose(ramp_hold_o) |->
      $past(vin_below_monitor_i) && $past(active_mode_o) == FDR_MODE_FLASH)
      else $error("hold raised without cause");
   a_hold_keep: assert property
      ($fell(ramp_hold_o) |-> active_mode_o != FDR_MODE_FLASH)
      else $error("hold dropped during flash");
   a_thr_field: assert property (wr_en_i && addr_i == FDR_ADDR_MONITOR
      |=> monitor_down_threshold_o == $past(wdata_i[4:2]))
      else $error("threshold field wrong");
   a_rev_read: assert property
      (rd_en_i && addr_i == FDR_ADDR_REVISION |=> rdata_o == REVISION)
      else $error("revision read wrong");
   a_rdata_stands: assert property (!rd_en_i |=> $stable(rdata_o))
      else $error("read data moved without read");
   c_flash: cover property (active_mode_o == FDR_MODE_FLASH);
   c_hold: cover property ($rose(ramp_hold_o));
   c_thermal: cover property (thermal_i && active_mode_o != 2'h0);
endmodule // fdr_regs_monitor
bind fdr_flash_driver_regs fdr_regs_monitor #(.REVISION(REVISION)) u_mon (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rd_en_i(rd_en_i),
   .wr_en_i(wr_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
   .vin_below_monitor_i(vin_below_monitor_i), .overvolt_i(overvolt_i),
   .led_short_i(led_short_i), .thermal_i(thermal_i),
   .active_mode_o(active_mode_o), .ramp_hold_o(ramp_hold_o),
   .monitor_down_threshold_o(monitor_down_threshold_o));

// ### verification/testbench.sv
// Testbench: register map, modes, time-out, faults and stop-and-hold
`timescale 1ns/1ps
module testbench;
   import fdr_pkg::*;
   localparam int STEP = 20;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic strobe_i = 1'b0;
   logic [4:0] ev = 5'h00;
   logic wr_en, rd_en, hold;
   logic [7:0] addr, wdata, rdata, d;
   logic [1:0] mode;
   logic [2:0] thr;
   logic [3:0] fcode;
   logic [2:0] tcode, framp, rup, rdn;
   logic ilim;
   int mismatches = 0;
   int tests_run = 0;
   logic [7:0] ra [6] = '{FDR_ADDR_MONITOR, FDR_ADDR_TORCH_RAMP,
      FDR_ADDR_FEATURES, FDR_ADDR_CURRENT, FDR_ADDR_ENABLE, FDR_ADDR_FLAGS};
   logic [7:0] rv [6] = '{8'h80, 8'h00, 8'h52, 8'h0F, 8'h00, 8'h00};
   logic [7:0] wm [6] = '{8'h9C, 8'h3F, 8'h7F, 8'h7F, 8'hF0, 8'h00};
   always #4 clk_sys_i = ~clk_sys_i;
   fdr_host_model u_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
      .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
   fdr_flash_driver_regs #(.TOUT_STEP_CYC(STEP)) u_dut (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wr_en_i(wr_en),
      .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
      .strobe_i(strobe_i), .tx_i(1'b0), .torch_pin_i(1'b0),
      .vin_below_monitor_i(ev[4]), .vin_below_undervoltage_lockout_i(ev[3]),
      .overvolt_i(ev[2]), .led_short_i(ev[1]), .thermal_i(ev[0]),
      .active_mode_o(mode), .ramp_hold_o(hold),
      .monitor_down_threshold_o(thr), .flash_code_o(fcode),
      .torch_code_o(tcode), .flash_ramp_o(framp), .inductor_limit_o(ilim),
      .torch_ramp_up_o(rup), .torch_ramp_down_o(rdn));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, d);
      chk("register", d, e);
   endtask
   task automatic close_out();
      if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Bounded wait for a mode; running out counts as a mismatch
   task automatic wt(input logic [1:0] m);
      int n;
      n = 0;
      while (mode !== m && n < 200) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk("mode", {6'h00, mode}, {6'h00, m});
      if (mode !== m) close_out();
   endtask
   task automatic pulse(input int k);
      @(negedge clk_sys_i);
      ev[k] = 1'b1;
      @(negedge clk_sys_i);
      ev[k] = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge clk_sys_i);
      nrst_i = 1'b1;
      rc(FDR_ADDR_REVISION, FDR_REVISION_DEF);
      u_host.wr(FDR_ADDR_REVISION, 8'hFF);
      rc(FDR_ADDR_REVISION, FDR_REVISION_DEF);
      rc(8'h02, 8'h00);
      chk("current fields", {1'b0, tcode, fcode}, FDR_RST_CURRENT);
      chk("feature fields", {1'b0, ilim, framp, 3'h0}, 8'h50);
      chk("ramp fields", {2'h0, rup, rdn}, FDR_RST_TORCH_RAMP);
      for (int i = 0; i < 6; i++) begin
         rc(ra[i], rv[i]);
         u_host.wr(ra[i], 8'hFC);
         rc(ra[i], 8'hFC & wm[i]);
         u_host.wr(ra[i], rv[i]);
      end
      // Field outputs follow their registers; time-out code stays at 2
      u_host.wr(FDR_ADDR_CURRENT, 8'h5A);
      u_host.wr(FDR_ADDR_FEATURES, 8'h2A);
      u_host.wr(FDR_ADDR_TORCH_RAMP, 8'h2C);
      chk("current fields", {1'b0, tcode, fcode}, 8'h5A);
      chk("feature fields", {1'b0, ilim, framp, 3'h0}, 8'h28);
      chk("ramp fields", {2'h0, rup, rdn}, 8'h2C);
      for (int m = 0; m < 4; m++) begin
         u_host.wr(FDR_ADDR_ENABLE, 8'(m));
         repeat (2) @(negedge clk_sys_i);
         chk("mode", {6'h00, mode}, 8'(m));
      end
      // Flash from register: default time-out code 2 runs 3 steps
      repeat (3 * STEP - 12) @(negedge clk_sys_i);
      chk("mode", {6'h00, mode}, 8'h03);
      wt(FDR_MODE_STANDBY);
      rc(FDR_ADDR_ENABLE, 8'h00);
      rc(FDR_ADDR_FLAGS, 8'h01);
      rc(FDR_ADDR_FLAGS, 8'h00);
      // Thermal keeps the enable bits; the other faults clear them
      for (int k = 0; k < 4; k++) begin
         u_host.wr(FDR_ADDR_ENABLE, 8'h02);
         wt(FDR_MODE_TORCH);
         pulse(k);
         repeat (4) @(negedge clk_sys_i);
         chk("mode", {6'h00, mode}, 8'h00);
         rc(FDR_ADDR_FLAGS, 8'h02 << k);
         repeat (3) @(negedge clk_sys_i);
         chk("mode", {6'h00, mode}, (k == 0) ? 8'h02 : 8'h00);
         rc(FDR_ADDR_ENABLE, (k == 0) ? 8'h02 : 8'h00);
         rc(FDR_ADDR_FLAGS, 8'h00);
      end
      for (int c = 0; c < 8; c++) begin
         u_host.wr(FDR_ADDR_MONITOR, 8'(c << 2));
         chk("threshold", {5'h00, thr}, 8'(c));
      end
      u_host.wr(FDR_ADDR_ENABLE, 8'h02);
      pulse(3);
      repeat (3) @(negedge clk_sys_i);
      chk("mode", {6'h00, mode}, 8'h02);
      rc(FDR_ADDR_FLAGS, 8'h00);
      u_host.wr(FDR_ADDR_ENABLE, 8'h00);
      u_host.wr(FDR_ADDR_MONITOR, 8'h80);
      pulse(4);
      rc(FDR_ADDR_FLAGS, 8'h20);
      u_host.wr(FDR_ADDR_ENABLE, 8'h83);
      wt(FDR_MODE_FLASH);
      ev[4] = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      chk("hold", {7'h00, hold}, 8'h01);
      ev[4] = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      chk("hold", {7'h00, hold}, 8'h01);
      wt(FDR_MODE_STANDBY);
      rc(FDR_ADDR_FLAGS, 8'h21);
      // Each strobe flash needs the enable value written again
      for (int r = 0; r < 2; r++) begin
         u_host.wr(FDR_ADDR_ENABLE, 8'h23);
         strobe_i = 1'b1;
         wt(FDR_MODE_FLASH);
         strobe_i = 1'b0;
         wt(FDR_MODE_STANDBY);
         rc(FDR_ADDR_ENABLE, 8'h20);
      end
      close_out();
   end
endmodule // testbench
